// ---- hw/dual_gpio_port_f_g.sv ----
/*
  Dual general-purpose port: an eight-pin and a five-pin bidirectional port
  with latches, directions, weak pull-ups and peripheral pin sharing, on APB.
  Assumes pads resolve the pin level from out, oe and pull-up, and that
  peripheral requests come from logic on pclk.
*/
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "gpio_fg_params.svh"

// How it works
// - First port has eight pins, each direction chosen on its own.
// - Direction 0 drives the latch out; direction 1 makes a readable input.
// - Pad bit 5 enables all first-port pull-ups; clear turns them off.
// - Pad bit 4 enables all second-port pull-ups; clear disables them.
// - A pin acting as output always has its pull-up off.
// - Reset leaves both ports' pull-ups disabled.
// - After reset first-port pins 7 to 1 are analog and read zero.
// - Second port has five pins with own direction and latch bits.
// - Enabled peripherals may force a pin to output, never to input.
// - Overrides never reach the direction register, reads show software values.
// - First-port pins 2 and 4 feed modulator carriers 1 and 2 as inputs.
// - Second-port pin 0 drives sync data over latch; direction 1 takes data in.
// - Second-port pin 3 carries async transmit, beating the latch value.
// - Second-port pin 0 feeds the async receiver while set as input.
// - Second-port pin 3 drives sync clock at 0, accepts clock at 1.
// - Timer clock inputs on pins 2 and 4 follow the pin regardless of direction.
// - Timer zero clock comes from pin 4 only when its map bit clears.
// - Timer three clock comes from pin 2 when its map bit sets, default.
// - Serial outputs on the second port may run open-drain by control register.
// - On the small package both pull-up bits are absent and read zero.
module dual_gpio_port_f_g
  import gpio_fg_pkg::*;
#(
  parameter int F_PINS        = 8,  // Width of the first port.
  parameter int G_PINS        = 5,  // Width of the second port.
  parameter bit SMALL_PACKAGE = 0   // Pull-up enables absent when set.
)(
  input  wire logic              pclk,          // APB and pin clock, 25 MHz.
  input  wire logic              presetn,       // Asynchronous reset, active low.
  input  wire logic              psel,          // APB select.
  input  wire logic              penable,       // APB access phase.
  input  wire logic              pwrite,        // APB direction.
  input  wire logic [7:0]        paddr,         // APB byte address.
  input  wire logic [31:0]       pwdata,        // APB write data.
  output logic      [31:0]       prdata,        // APB read data.
  output logic                   pready,        // APB ready.
  output logic                   pslverr,       // APB error, unmapped offset.
  input  wire logic [F_PINS-1:0] pin_f_in,      // First port pad levels.
  output logic      [F_PINS-1:0] pin_f_out,     // First port drive levels.
  output logic      [F_PINS-1:0] pin_f_oe,      // First port drive enables.
  output logic      [F_PINS-1:0] pin_f_pullup,  // First port weak pull-ups.
  input  wire logic [G_PINS-1:0] pin_g_in,      // Second port pad levels.
  output logic      [G_PINS-1:0] pin_g_out,     // Second port drive levels.
  output logic      [G_PINS-1:0] pin_g_oe,      // Second port drive enables.
  output logic      [G_PINS-1:0] pin_g_pullup,  // Second port weak pull-ups.
  input  wire periph_req_s       periph_req,    // Peripheral pin requests.
  output periph_ret_s            periph_ret     // Pin levels to peripherals.
);

  // Software-visible state, then pad synchronisers and filtered levels.
  logic [F_PINS-1:0] latch_f_ff;
  logic [F_PINS-1:0] dir_f_ff;
  logic [F_PINS-1:0] analog_ff;
  logic [G_PINS-1:0] latch_g_ff;
  logic [G_PINS-1:0] dir_g_ff;
  logic              pu_first_ff;
  logic              pu_second_ff;
  logic              open_drain_ff;
  logic [1:0]        timer_map_ff;
  logic [F_PINS-1:0] sync1_f_ff;
  logic [F_PINS-1:0] sync2_f_ff;
  logic [F_PINS-1:0] sync3_f_ff;
  logic [F_PINS-1:0] level_f_ff;
  logic [G_PINS-1:0] sync1_g_ff;
  logic [G_PINS-1:0] sync2_g_ff;
  logic [G_PINS-1:0] sync3_g_ff;
  logic [G_PINS-1:0] level_g_ff;

  // Bus answer and pin drive registers, then combinational helpers.
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [F_PINS-1:0] pin_f_out_ff;
  logic [F_PINS-1:0] pin_f_oe_ff;
  logic [F_PINS-1:0] pin_f_pu_ff;
  logic [G_PINS-1:0] pin_g_out_ff;
  logic [G_PINS-1:0] pin_g_oe_ff;
  logic [G_PINS-1:0] pin_g_pu_ff;
  periph_ret_s       periph_ret_ff;
  logic              setup_phase;
  logic              wr_take;
  logic              mapped;
  logic [31:0]       nxt_prdata;
  logic [F_PINS-1:0] eff_dir_f;
  logic [G_PINS-1:0] eff_dir_g;
  logic [F_PINS-1:0] nxt_out_f;
  logic [G_PINS-1:0] nxt_out_g;
  logic [G_PINS-1:0] serial_pin;
  logic [G_PINS-1:0] od_release;

  // Answer comes one cycle after setup, so pready rises in the access phase.
  assign setup_phase = psel & ~penable;
  assign wr_take     = psel & penable & pready_ff & pwrite;

  // Read mux and address decode; unmapped offsets read zero with an error.
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    mapped     = 1'b1;
    unique case (paddr)
      `OFS_PORT_F_PIN_LEVELS:
        nxt_prdata[F_PINS-1:0] = level_f_ff & ~analog_ff;
      `OFS_PORT_F_OUTPUT_LATCH:
        nxt_prdata[F_PINS-1:0] = latch_f_ff;
      `OFS_PORT_F_DIRECTION:
        nxt_prdata[F_PINS-1:0] = dir_f_ff;
      `OFS_PORT_G_PIN_LEVELS:
        nxt_prdata[G_PINS-1:0] = level_g_ff;
      `OFS_PORT_G_OUTPUT_LATCH:
        nxt_prdata[G_PINS-1:0] = latch_g_ff;
      `OFS_PORT_G_DIRECTION:
        nxt_prdata[G_PINS-1:0] = dir_g_ff;
      `OFS_PAD_CONFIGURATION:
      begin
        nxt_prdata[`PAD_PU_FIRST_BIT]  = pu_first_ff;
        nxt_prdata[`PAD_PU_SECOND_BIT] = pu_second_ff;
      end
      `OFS_OPEN_DRAIN_CONTROL:
        nxt_prdata[`OD_SERIAL_BIT] = open_drain_ff;
      `OFS_ANALOG_SELECT:
        nxt_prdata[F_PINS-1:0] = analog_ff;
      `OFS_TIMER_PIN_MAP:
        nxt_prdata[1:0] = timer_map_ff;
      default:
        mapped = 1'b0;
    endcase
  end

  // Bus answer registers, loaded in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup_phase;
      pslverr_ff <= setup_phase & ~mapped;
      prdata_ff  <= (setup_phase & ~pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  // Port latches; a write to the pin register lands in the latch.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_f_ff <= `RST_PORT_F_LATCH;
      latch_g_ff <= `RST_PORT_G_LATCH;
    end
    else if (wr_take)
    begin
      if (paddr == `OFS_PORT_F_PIN_LEVELS || paddr == `OFS_PORT_F_OUTPUT_LATCH)
        latch_f_ff <= pwdata[F_PINS-1:0];
      if (paddr == `OFS_PORT_G_PIN_LEVELS || paddr == `OFS_PORT_G_OUTPUT_LATCH)
        latch_g_ff <= pwdata[G_PINS-1:0];
    end
  end

  // Directions hold only software values; overrides never write here.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_f_ff <= `RST_PORT_F_DIRECTION;
      dir_g_ff <= `RST_PORT_G_DIRECTION;
    end
    else if (wr_take)
    begin
      if (paddr == `OFS_PORT_F_DIRECTION)
        dir_f_ff <= pwdata[F_PINS-1:0];
      if (paddr == `OFS_PORT_G_DIRECTION)
        dir_g_ff <= pwdata[G_PINS-1:0];
    end
  end

  // Pad, open-drain, analog and timer mapping controls.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pu_first_ff   <= 1'b0;
      pu_second_ff  <= 1'b0;
      open_drain_ff <= `RST_OPEN_DRAIN;
      analog_ff     <= `RST_ANALOG_SELECT;
      timer_map_ff  <= `RST_TIMER_PIN_MAP;
    end
    else if (wr_take)
    begin
      // The small package has no pull-up bits, so they stay zero.
      if (paddr == `OFS_PAD_CONFIGURATION)
      begin
        pu_first_ff  <= pwdata[`PAD_PU_FIRST_BIT] & ~SMALL_PACKAGE;
        pu_second_ff <= pwdata[`PAD_PU_SECOND_BIT] & ~SMALL_PACKAGE;
      end
      if (paddr == `OFS_OPEN_DRAIN_CONTROL)
        open_drain_ff <= pwdata[`OD_SERIAL_BIT];
      if (paddr == `OFS_ANALOG_SELECT)
        analog_ff <= pwdata[F_PINS-1:0];
      if (paddr == `OFS_TIMER_PIN_MAP)
        timer_map_ff <= pwdata[1:0];
    end
  end

  // Three-stage sampling of the pads; a level counts once stages two and
  // three agree, which rejects a single-cycle glitch at a small latency cost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_f_ff <= '0;
      sync2_f_ff <= '0;
      sync3_f_ff <= '0;
      level_f_ff <= '0;
      sync1_g_ff <= '0;
      sync2_g_ff <= '0;
      sync3_g_ff <= '0;
      level_g_ff <= '0;
    end
    else
    begin
      sync1_f_ff <= pin_f_in;
      sync2_f_ff <= sync1_f_ff;
      sync3_f_ff <= sync2_f_ff;
      level_f_ff <= (sync3_f_ff & ~(sync2_f_ff ^ sync3_f_ff))
                  | (level_f_ff & (sync2_f_ff ^ sync3_f_ff));
      sync1_g_ff <= pin_g_in;
      sync2_g_ff <= sync1_g_ff;
      sync3_g_ff <= sync2_g_ff;
      level_g_ff <= (sync3_g_ff & ~(sync2_g_ff ^ sync3_g_ff))
                  | (level_g_ff & (sync2_g_ff ^ sync3_g_ff));
    end
  end

  // First port: the modulator output forces pin 6 to drive its level.
  always_comb
  begin
    eff_dir_f = dir_f_ff;
    nxt_out_f = latch_f_ff;
    if (periph_req.mod_out_en)
    begin
      eff_dir_f[6] = 1'b0;
      nxt_out_f[6] = periph_req.mod_out_data;
    end
  end

  // Second port: serial and CAN outputs win over the latch; serial pins
  // may release high instead of driving it when open-drain is chosen.
  always_comb
  begin
    eff_dir_g  = dir_g_ff;
    nxt_out_g  = latch_g_ff;
    serial_pin = '0;
    if (periph_req.serial_sync_mode && periph_req.sync_data_oe)
    begin
      eff_dir_g[0]  = 1'b0;
      nxt_out_g[0]  = periph_req.sync_data_out;
      serial_pin[0] = 1'b1;
    end
    if (periph_req.can_tx_en)
    begin
      eff_dir_g[1] = 1'b0;
      nxt_out_g[1] = periph_req.can_tx_data;
    end
    if (!periph_req.serial_sync_mode && periph_req.serial_tx_en)
    begin
      eff_dir_g[3]  = 1'b0;
      nxt_out_g[3]  = periph_req.serial_tx_data;
      serial_pin[3] = 1'b1;
    end
    else if (periph_req.serial_sync_mode && periph_req.sync_clock_master
             && !dir_g_ff[3])
    begin
      nxt_out_g[3]  = periph_req.sync_clock_out;
      serial_pin[3] = 1'b1;
    end
    od_release = serial_pin & nxt_out_g & {G_PINS{open_drain_ff}};
  end

  // Pin drive, per bit of each port; pull-ups only on pins not driving.
  genvar gi;
  generate
    for (gi = 0; gi < F_PINS; gi++)
    begin : g_pin_f
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_f_out_ff[gi] <= 1'b0;
          pin_f_oe_ff[gi]  <= 1'b0;
          pin_f_pu_ff[gi]  <= 1'b0;
        end
        else
        begin
          pin_f_out_ff[gi] <= nxt_out_f[gi];
          pin_f_oe_ff[gi]  <= ~eff_dir_f[gi];
          pin_f_pu_ff[gi]  <= pu_first_ff & eff_dir_f[gi];
        end
      end
    end
    for (gi = 0; gi < G_PINS; gi++)
    begin : g_pin_g
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_g_out_ff[gi] <= 1'b0;
          pin_g_oe_ff[gi]  <= 1'b0;
          pin_g_pu_ff[gi]  <= 1'b0;
        end
        else
        begin
          pin_g_out_ff[gi] <= nxt_out_g[gi] & ~od_release[gi];
          pin_g_oe_ff[gi]  <= ~eff_dir_g[gi] & ~od_release[gi];
          pin_g_pu_ff[gi]  <= pu_second_ff & eff_dir_g[gi];
        end
      end
    end
  endgenerate

  // Levels handed to peripherals; inputs idle low except receive, which
  // idles high so the receiver sees no false start bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_ret_ff <= '0;
    else
    begin
      periph_ret_ff.modulator_source_in  <= level_f_ff[0] & dir_f_ff[0];
      periph_ret_ff.carrier_in_one       <= level_f_ff[2] & dir_f_ff[2];
      periph_ret_ff.carrier_in_two       <= level_f_ff[4] & dir_f_ff[4];
      periph_ret_ff.serial_receive_in    <= ~dir_g_ff[0] | level_g_ff[0];
      periph_ret_ff.sync_data_in         <= level_g_ff[0] & dir_g_ff[0];
      periph_ret_ff.sync_clock_in        <= level_g_ff[3] & dir_g_ff[3];
      periph_ret_ff.timer_zero_clock_in  <= level_g_ff[4]
                                          & ~timer_map_ff[`MAP_TIMER_ZERO_BIT];
      periph_ret_ff.timer_three_clock_in <= level_g_ff[2]
                                          & timer_map_ff[`MAP_TIMER_THREE_BIT];
    end
  end

  // Outputs straight from flip-flops.
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign pin_f_out    = pin_f_out_ff;
  assign pin_f_oe     = pin_f_oe_ff;
  assign pin_f_pullup = pin_f_pu_ff;
  assign pin_g_out    = pin_g_out_ff;
  assign pin_g_oe     = pin_g_oe_ff;
  assign pin_g_pullup = pin_g_pu_ff;
  assign periph_ret   = periph_ret_ff;

endmodule : dual_gpio_port_f_g

// ---- hw/gpio_fg_params.svh ----
/*
  Register offsets, field positions and reset values of the dual port block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef GPIO_FG_PARAMS_SVH
`define GPIO_FG_PARAMS_SVH

// Byte offsets on the APB, one aligned word per register.
`define OFS_PORT_F_PIN_LEVELS    8'h00
`define OFS_PORT_F_OUTPUT_LATCH  8'h04
`define OFS_PORT_F_DIRECTION     8'h08
`define OFS_PORT_G_PIN_LEVELS    8'h0c
`define OFS_PORT_G_OUTPUT_LATCH  8'h10
`define OFS_PORT_G_DIRECTION     8'h14
`define OFS_PAD_CONFIGURATION    8'h18
`define OFS_OPEN_DRAIN_CONTROL   8'h1c
`define OFS_ANALOG_SELECT        8'h20
`define OFS_TIMER_PIN_MAP        8'h24

// Field positions.
`define PAD_PU_FIRST_BIT         5
`define PAD_PU_SECOND_BIT        4
`define OD_SERIAL_BIT            0
`define MAP_TIMER_ZERO_BIT       0
`define MAP_TIMER_THREE_BIT      1

// Reset values.
`define RST_PORT_F_LATCH         8'h00
`define RST_PORT_F_DIRECTION     8'hff
`define RST_PORT_G_LATCH         5'h00
`define RST_PORT_G_DIRECTION     5'h1f
`define RST_PAD_PULLUPS          2'h0
`define RST_OPEN_DRAIN           1'h0
`define RST_ANALOG_SELECT        8'hfe
`define RST_TIMER_PIN_MAP        2'h3

`endif

// ---- hw/gpio_fg_pkg.sv ----
/*
  Types shared by the dual port block: peripheral request and delivery bundles.
  Assumes the params header sits beside it.
*/
package gpio_fg_pkg;
  `include "gpio_fg_params.svh"

  // What the peripherals ask of the pins.
  typedef struct packed {
    logic serial_sync_mode;   // Serial unit in synchronous mode.
    logic serial_tx_en;       // Asynchronous transmit active.
    logic serial_tx_data;     // Asynchronous transmit level.
    logic sync_data_oe;       // Synchronous data being driven.
    logic sync_data_out;      // Synchronous data level.
    logic sync_clock_master;  // Serial unit makes the clock.
    logic sync_clock_out;     // Synchronous clock level.
    logic can_tx_en;          // CAN transmitter active.
    logic can_tx_data;        // CAN transmit level.
    logic mod_out_en;         // Modulator output active.
    logic mod_out_data;       // Modulated output level.
  } periph_req_s;

  // What the pins hand to the peripherals.
  typedef struct packed {
    logic modulator_source_in;
    logic carrier_in_one;
    logic carrier_in_two;
    logic serial_receive_in;
    logic sync_data_in;
    logic sync_clock_in;
    logic timer_zero_clock_in;
    logic timer_three_clock_in;
  } periph_ret_s;
endpackage : gpio_fg_pkg

// ---- dv/gpio_fg_checker_properties.sv ----
/*
  Checker for the dual port block: APB answer, pull-ups and peripheral pins.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module gpio_fg_checker
  import gpio_fg_pkg::*;
#(
  parameter int F_PINS = 8,  // First port width.
  parameter int G_PINS = 5   // Second port width.
)(
  input wire logic              pclk,          // Clock.
  input wire logic              presetn,       // Reset, active low.
  input wire logic              psel,          // APB select.
  input wire logic              penable,       // APB access.
  input wire logic              pready,        // APB ready.
  input wire logic [F_PINS-1:0] pin_f_out,     // First port levels.
  input wire logic [F_PINS-1:0] pin_f_oe,      // First port enables.
  input wire logic [F_PINS-1:0] pin_f_pullup,  // First port pull-ups.
  input wire logic [G_PINS-1:0] pin_g_in,      // Second port pads.
  input wire logic [G_PINS-1:0] pin_g_out,     // Second port levels.
  input wire logic [G_PINS-1:0] pin_g_oe,      // Second port enables.
  input wire logic [G_PINS-1:0] pin_g_pullup,  // Second port pull-ups.
  input wire periph_req_s       periph_req,    // Peripheral requests.
  input wire periph_ret_s       periph_ret     // Peripheral inputs.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The slave never stretches a transfer, so ready must follow setup at once.
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_pullup_f_out: assert property ((pin_f_oe & pin_f_pullup) == '0)
    else $error("first port pull-up on a driven pin");
  a_pullup_g_out: assert property ((pin_g_oe & pin_g_pullup) == '0)
    else $error("second port pull-up on a driven pin");
  a_reset_pullups: assert property ($rose(presetn) |->
    !(|pin_f_pullup) && !(|pin_g_pullup))
    else $error("pull-up on after reset");
  // Open-drain may release a high level, so a released pin must mean high.
  a_sync_data_drive: assert property (
    periph_req.serial_sync_mode && periph_req.sync_data_oe |=>
    (pin_g_oe[0] ? pin_g_out[0] == $past(periph_req.sync_data_out)
                 : $past(periph_req.sync_data_out)))
    else $error("sync data not on second port pin 0");
  a_async_tx_drive: assert property (
    periph_req.serial_tx_en && !periph_req.serial_sync_mode |=>
    (pin_g_oe[3] ? pin_g_out[3] == $past(periph_req.serial_tx_data)
                 : $past(periph_req.serial_tx_data)))
    else $error("transmit not on second port pin 3");
  a_can_tx_drive: assert property (periph_req.can_tx_en |=>
    pin_g_oe[1] && pin_g_out[1] == $past(periph_req.can_tx_data))
    else $error("can transmit not on second port pin 1");
  a_mod_out_drive: assert property (periph_req.mod_out_en |=>
    pin_f_oe[6] && pin_f_out[6] == $past(periph_req.mod_out_data))
    else $error("modulator output not on first port pin 6");
  // Seven quiet samples cover the three sync flops, the filter and the output flop.
  a_timer_follows_pin: assert property ($stable(pin_g_in[2]) [*7] |->
    periph_ret.timer_three_clock_in == pin_g_in[2])
    else $error("timer three clock does not follow its pin");
endmodule : gpio_fg_checker

bind dual_gpio_port_f_g gpio_fg_checker #(.F_PINS(F_PINS), .G_PINS(G_PINS)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pin_f_out(pin_f_out), .pin_f_oe(pin_f_oe), .pin_f_pullup(pin_f_pullup),
  .pin_g_in(pin_g_in), .pin_g_out(pin_g_out), .pin_g_oe(pin_g_oe),
  .pin_g_pullup(pin_g_pullup), .periph_req(periph_req), .periph_ret(periph_ret));

// ---- dv/pin_pads_model.sv ----
/*
  Pad model: resolves each pin from the block's drive, an outside driver
  and the weak pull-up. Assumes the bench never drives a pin the block drives.
*/
`timescale 1ns/10ps
module pin_pads_model #(
  parameter int W = 8  // Pin count.
)(
  input wire logic         pclk,     // Clock for the float pattern.
  input wire logic [W-1:0] out,      // Block drive level.
  input wire logic [W-1:0] oe,       // Block drive enable.
  input wire logic [W-1:0] pu,       // Weak pull-up.
  input wire logic [W-1:0] ext_val,  // Outside level.
  input wire logic [W-1:0] ext_en,   // Outside drive enable.
  output logic     [W-1:0] lvl       // Resolved pin level.
);
  logic float_ff = 1'b0;

  // A floating pin wanders every cycle, so nothing reads it as a stale value.
  always @(posedge pclk) float_ff <= ~float_ff;

  // Block drive wins, then the outside driver, then the pull-up.
  always_comb
    for (int i = 0; i < W; i++)
      lvl[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : float_ff;
endmodule : pin_pads_model

// ---- dv/testbench.sv ----
/*
  Self-checking bench for the dual port block, registers reached over APB.
  Assumes the pad model and the checker are compiled before it.
*/
`timescale 1ns/10ps
`include "gpio_fg_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench
  import gpio_fg_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, pin_f_in, pin_f_out, pin_f_oe, pin_f_pu, ext_f, ext_f_en;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0]  pin_g_in, pin_g_out, pin_g_oe, pin_g_pu, ext_g, ext_g_en;
  periph_req_s periph_req;
  periph_ret_s periph_ret;
  int          fail_count, cmp_count, cyc;

  dual_gpio_port_f_g dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_f_in(pin_f_in), .pin_f_out(pin_f_out), .pin_f_oe(pin_f_oe),
    .pin_f_pullup(pin_f_pu), .pin_g_in(pin_g_in), .pin_g_out(pin_g_out), .pin_g_oe(pin_g_oe),
    .pin_g_pullup(pin_g_pu), .periph_req(periph_req), .periph_ret(periph_ret));
  pin_pads_model #(.W(8)) pads_f (.pclk(pclk), .out(pin_f_out), .oe(pin_f_oe), .pu(pin_f_pu),
    .ext_val(ext_f), .ext_en(ext_f_en), .lvl(pin_f_in));
  pin_pads_model #(.W(5)) pads_g (.pclk(pclk), .out(pin_g_out), .oe(pin_g_oe), .pu(pin_g_pu),
    .ext_val(ext_g), .ext_en(ext_g_en), .lvl(pin_g_in));

  // Free-running 25 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // One APB transfer after an idle edge, so psel is never set twice in one
  // step; the request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rdat)
  endtask : rchk

  // Long enough for a register change or a pad change to reach every output.
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask : settle

  task automatic t_reset;
    `CHK("pullups", 13'h0, {pin_f_pu, pin_g_pu})
    `CHK("f oe", 8'h00, pin_f_oe)
    rchk(`OFS_PORT_F_DIRECTION, 32'hff);
    rchk(`OFS_PORT_G_DIRECTION, 32'h1f);
    rchk(`OFS_PORT_F_OUTPUT_LATCH, 32'h0);
    rchk(`OFS_PAD_CONFIGURATION, 32'h0);
    rchk(`OFS_TIMER_PIN_MAP, 32'h3);
    rchk(`OFS_PORT_F_PIN_LEVELS, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
  endtask : t_reset

  task automatic t_dir_latch;
    ext_f_en <= 8'h00;
    wr(`OFS_PAD_CONFIGURATION, 32'h30);
    wr(`OFS_PORT_F_PIN_LEVELS, 32'h5a);
    rchk(`OFS_PORT_F_OUTPUT_LATCH, 32'h5a);
    wr(`OFS_PORT_F_OUTPUT_LATCH, 32'ha5);
    wr(`OFS_PORT_F_DIRECTION, 32'h0f);
    wr(`OFS_ANALOG_SELECT, 32'h0);
    settle();
    `CHK("f oe", 8'hf0, pin_f_oe)
    `CHK("f out", 4'ha, pin_f_out[7:4])
    `CHK("f pullup", 8'h0f, pin_f_pu)
    rchk(`OFS_PORT_F_PIN_LEVELS, 32'haf);
    rchk(`OFS_PORT_F_OUTPUT_LATCH, 32'ha5);
  endtask : t_dir_latch

  task automatic t_pullup;
    wr(`OFS_PAD_CONFIGURATION, 32'h10);
    settle();
    `CHK("f pullup off", 8'h00, pin_f_pu)
    `CHK("g pullup on", 5'h1f, pin_g_pu)
    wr(`OFS_PAD_CONFIGURATION, 32'h20);
    settle();
    `CHK("f pullup on", 8'h0f, pin_f_pu)
    `CHK("g pullup off", 5'h00, pin_g_pu)
  endtask : t_pullup

  task automatic t_override;
    ext_g_en <= 5'h00;
    periph_req <= 11'b1_0_0_1_0_1_1_1_1_1_1;
    wr(`OFS_PORT_G_DIRECTION, 32'h17);
    settle();
    `CHK("g oe", 5'h0b, pin_g_oe & 5'h0b)
    `CHK("g out", 5'h0a, pin_g_out & 5'h0b)
    `CHK("f6 oe", 1'b1, pin_f_oe[6])
    rchk(`OFS_PORT_G_DIRECTION, 32'h17);
    rchk(`OFS_PORT_F_DIRECTION, 32'h0f);
    periph_req <= 11'b0_1_0_0_0_0_0_0_0_0_0;
    wr(`OFS_PORT_G_DIRECTION, 32'h1f);
    wr(`OFS_OPEN_DRAIN_CONTROL, 32'h1);
    settle();
    `CHK("tx low", 2'b10, {pin_g_oe[3], pin_g_out[3]})
    periph_req.serial_tx_data <= 1'b1;
    settle();
    `CHK("tx released", 1'b0, pin_g_oe[3])
    periph_req <= '0;
  endtask : t_override

  task automatic t_inputs;
    ext_f_en <= 8'hff;
    ext_g_en <= 5'h1f;
    wr(`OFS_PORT_F_DIRECTION, 32'hff);
    wr(`OFS_TIMER_PIN_MAP, 32'h2);
    for (int v = 1; v >= 0; v--)
    begin
      ext_f <= v ? 8'h15 : 8'h00;
      ext_g <= v ? 5'h1d : 5'h02;
      settle();
      `CHK("carriers", {2{v[0]}}, {periph_ret.carrier_in_one, periph_ret.carrier_in_two})
      `CHK("modulator source", v[0], periph_ret.modulator_source_in)
      `CHK("receive", v[0], periph_ret.serial_receive_in)
      `CHK("sync data in", v[0], periph_ret.sync_data_in)
      `CHK("sync clock in", v[0], periph_ret.sync_clock_in)
      `CHK("timer zero", v[0], periph_ret.timer_zero_clock_in)
      `CHK("timer three", v[0], periph_ret.timer_three_clock_in)
    end
    rchk(`OFS_PORT_G_PIN_LEVELS, 32'h02);
    ext_g_en <= 5'h00;
    wr(`OFS_PORT_G_OUTPUT_LATCH, 32'h14);
    wr(`OFS_PORT_G_DIRECTION, 32'h00);
    wr(`OFS_PORT_F_DIRECTION, 32'h00);
    ext_f_en <= 8'h00;
    settle();
    `CHK("timers as outputs", 2'b11,
         {periph_ret.timer_zero_clock_in, periph_ret.timer_three_clock_in})
    `CHK("carrier gated", 1'b0, periph_ret.carrier_in_one)
  endtask : t_inputs

  // Main sequence: reset, then every scenario in turn.
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; periph_req = '0;
    ext_f = 8'hff; ext_f_en = 8'hff; ext_g = 5'h15; ext_g_en = 5'h1f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_dir_latch();
    t_pullup();
    t_override();
    t_inputs();
    close_out();
  end
endmodule : testbench
